// ### chain_mem_model.sv
`timescale 1ns/1ps
module chain_mem_model
	import dma_blk_pkg::*;
#(
	parameter int LAT = 3
)(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// fetch request from the block
	input  wire logic         chain_req_r,
	input  wire logic [20:0]  chain_addr_r,
	// stored block and answer
	input  wire logic [127:0] img,
	output logic              chain_ack,
	output logic      [127:0] chain_data,
	output logic      [20:0]  last_addr
);
	int wait_cnt;
	// ==========================================
	// memory answer
	// data toggles outside the ack cycle so a stale word never passes
	always @(negedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt   <= 0;
			chain_ack  <= 1'b0;
			chain_data <= '1;
			last_addr  <= '0;
		end else if (chain_ack) begin
			chain_ack  <= 1'b0;
			chain_data <= ~img;
		end else if (chain_req_r && wait_cnt == LAT) begin
			chain_ack  <= 1'b1;
			chain_data <= img;
			last_addr  <= chain_addr_r;
			wait_cnt   <= 0;
		end else begin
			wait_cnt   <= chain_req_r ? wait_cnt + 1 : 0;
			chain_data <= ~chain_data;
		end
	end
endmodule

// ### dma_blk_pkg.sv
// Contract
// - Block registers are reached only as whole quad-words, never narrower.
// - Each control block is 128 bits: index, X, Y, control words.
// - A block load is an aligned quad-word, from chaining or direct write.
// - Loading type 000 clears status, flushes request counters, resets channel state.
// - Loading an active block into an active channel raises a reload interrupt.
// - Completion interrupt only after count reaches zero and last element moved.
// - Enabled link receive channel moves each received word until block done.
// - Ready link transmitter gets one quad-word per request until block done.
// - Channels 0 to 3 are external-port, each with source and destination blocks.
// - Channels 4 to 7 are link 0 to 3 transmit, one block each.
// - Channels 8 to 11 are link 0 to 3 receive, one block each.
// - Channels 12 and 13 are write-triggered, one destination block each.
// - Index word is a 32-bit address pointer to memory or link.
// - X word: modify in low 16 bits, count in high 16 bits.
// - X count counts normal words; X modify steps in normal words.
// - Types 011 and 111 split X and Y into 10-bit count, 22-bit modify.
// - Y modify steps from a row's last element to the next row's first.
// - Control word holds a control portion and a chaining portion with pointer.
// - With chaining on, next block is fetched from the chain pointer on completion.
// - Interrupt-enable clear means no completion interrupt.
// - Two-dimensional enable clear means Y word ignored, one-dimensional transfer.
package dma_blk_pkg;
	localparam int NUM_BLK  = 18;
	localparam int NUM_CHAN = 14;
	localparam int NUM_LINK = 4;
	localparam int NUM_EXT  = 4;
	localparam int NUM_WT   = 2;
	// word positions inside a quad-word block
	localparam int IDX_LSB  = 0;
	localparam int XW_LSB   = 32;
	localparam int YW_LSB   = 64;
	localparam int CW_LSB   = 96;
	// control word fields
	localparam int CHAIN_POINTER_LSB = 0;
	localparam int CHAIN_POINTER_W   = 19;
	localparam int CHTG_LSB = 19;
	localparam int CHAIN_ENABLE_BIT = 22;
	localparam int INT_BIT  = 24;
	localparam int TWOD_BIT = 27;
	localparam int TYPE_LSB = 29;
	// count field positions, short and long split
	localparam int CNT_S_LSB = 16;
	localparam int CNT_L_LSB = 22;
	localparam logic [2:0] TYPE_OFF      = 3'h0;
	localparam logic [2:0] TYPE_INT_LONG = 3'h3;
	localparam logic [2:0] TYPE_EXT_LONG = 3'h7;
	// block numbering
	localparam int BLK_SRC = 0;
	localparam int BLK_DST = 4;
	localparam int BLK_LTX = 8;
	localparam int BLK_LRX = 12;
	localparam int BLK_WT  = 16;
	// channel numbering
	localparam int CH_LTX = 4;
	localparam int CH_LRX = 8;
	localparam int CH_WT  = 12;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;

	typedef enum logic [0:0] {
		CF_IDLE = 1'b0,
		CF_WAIT = 1'b1
	} chain_fsm_e;

	// lowest set bit; zero when none
	function automatic logic [4:0] first_set(input logic [17:0] v);
		first_set = 5'h00;
		for (int i = 17; i >= 0; i--) begin
			if (v[i]) first_set = 5'(i);
		end
	endfunction
endpackage

// ### dma_blk_slot.sv
`timescale 1ns/1ps
module dma_blk_slot
	import dma_blk_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// load and advance
	input  wire logic         load,
	input  wire logic [127:0] ld_data,
	input  wire logic         step,
	// state
	output logic      [127:0] words_r,
	output logic      [31:0]  addr_r,
	output logic              act_r,
	output logic              last
);
	function automatic logic [15:0] cnt_of(input logic [31:0] w, input logic lng);
		cnt_of = lng ? {6'h00, w[CNT_L_LSB +: 10]} : w[CNT_S_LSB +: 16];
	endfunction

	function automatic logic [31:0] mod_of(input logic [31:0] w, input logic lng);
		mod_of = lng ? {{10{w[21]}}, w[21:0]} : {{16{w[15]}}, w[15:0]};
	endfunction

	function automatic logic is_long(input logic [2:0] ty);
		is_long = (ty == TYPE_INT_LONG) || (ty == TYPE_EXT_LONG);
	endfunction

	logic [15:0] xcnt_r;
	logic [15:0] ycnt_r;
	wire  [31:0] cw     = words_r[CW_LSB +: 32];
	wire  [2:0]  ld_ty  = ld_data[CW_LSB + TYPE_LSB +: 3];
	wire         llng   = is_long(ld_ty);
	wire         lng    = is_long(cw[TYPE_LSB +: 3]);
	// y count of one makes a plain line; y word never read then
	wire  [15:0] ld_x   = cnt_of(ld_data[XW_LSB +: 32], llng);
	wire  [15:0] ld_y   = ld_data[CW_LSB + TWOD_BIT] ?
	                      cnt_of(ld_data[YW_LSB +: 32], llng) : 16'h0001;
	wire  [15:0] xinit  = cnt_of(words_r[XW_LSB +: 32], lng);
	wire  [31:0] xmod   = mod_of(words_r[XW_LSB +: 32], lng);
	wire  [31:0] ymod   = mod_of(words_r[YW_LSB +: 32], lng);
	wire         adv    = step & act_r;
	wire         row_end  = (xcnt_r == 16'h0001);
	wire         row_more = cw[TWOD_BIT] & (ycnt_r > 16'h0001);
	wire  [15:0] xcnt_nxt = load ? ld_x : !adv ? xcnt_r :
	                        row_end ? (row_more ? xinit : 16'h0000) : xcnt_r - 16'h0001;
	wire  [15:0] ycnt_nxt = load ? ld_y :
	                        (adv & row_end & row_more) ? ycnt_r - 16'h0001 : ycnt_r;
	// row jump replaces the x step at a row's end
	wire  [31:0] addr_nxt = load ? ld_data[IDX_LSB +: 32] : !adv ? addr_r :
	                        (row_end & row_more) ? addr_r + ymod : addr_r + xmod;
	wire         act_nxt  = load ? (ld_ty != TYPE_OFF && ld_x != 16'h0000) : act_r & ~last;

	assign last = adv & row_end & ~row_more;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			words_r <= {4{WORD_RST}};
			addr_r  <= WORD_RST;
			xcnt_r  <= 16'h0000;
			ycnt_r  <= 16'h0000;
			act_r   <= 1'b0;
		end else begin
			if (load) words_r <= ld_data;
			addr_r <= addr_nxt;
			xcnt_r <= xcnt_nxt;
			ycnt_r <= ycnt_nxt;
			act_r  <= act_nxt;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_split_count: assert property (
		load && llng |=> xcnt_r == {6'h00, $past(ld_data[XW_LSB + CNT_L_LSB +: 10])})
		else $error("long split count not taken from upper ten bits");

	a_row_jump: assert property (
		adv && row_end && row_more && !load |=> addr_r == $past(addr_r + ymod))
		else $error("row end did not apply y modify");
endmodule

// ### dma_tcb_channel_setup_bench.sv
`timescale 1ns/1ps
module dma_tcb_channel_setup_bench;
	import dma_blk_pkg::*;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         blk_wr = 1'b0;
	logic         blk_rd = 1'b0;
	logic         blk_quad = 1'b0;
	logic [4:0]   blk_sel = '0;
	logic [127:0] blk_wdata = '0;
	logic [127:0] blk_rdata_r;
	logic         blk_rvalid_r;
	logic         chain_req_r;
	logic [20:0]  chain_addr_r;
	logic         chain_ack;
	logic [127:0] chain_data;
	logic [9:0]   req = '0;
	logic [3:0]   link_tx_ready;
	logic [3:0]   link_rx_valid;
	logic [1:0]   auto_wr;
	logic         xfer_valid_r;
	logic [3:0]   xfer_chan_r;
	logic [31:0]  xfer_src_r;
	logic [31:0]  xfer_dst_r;
	logic [17:0]  blk_active;
	logic [17:0]  blk_done_r;
	logic [17:0]  blk_err_r;
	logic         irq_done_r;
	logic         irq_reload_r;
	logic [127:0] img = '0;
	logic [20:0]  last_addr;
	logic [67:0]  last_x;
	int           error_cnt = 0;
	int           n_checks = 0;
	int           n_done = 0;
	int           n_reload = 0;
	int           n_xf = 0;

	assign {auto_wr, link_rx_valid, link_tx_ready} = req;
	always #2 clk = ~clk;

	dma_tcb_setup DUT (.clk(clk), .rst_n(rst_n), .blk_wr(blk_wr), .blk_rd(blk_rd),
		.blk_quad(blk_quad), .blk_sel(blk_sel), .blk_wdata(blk_wdata),
		.blk_rdata_r(blk_rdata_r), .blk_rvalid_r(blk_rvalid_r), .chain_req_r(chain_req_r),
		.chain_addr_r(chain_addr_r), .chain_ack(chain_ack), .chain_data(chain_data),
		.link_tx_ready(link_tx_ready), .link_rx_valid(link_rx_valid), .auto_wr(auto_wr),
		.xfer_valid_r(xfer_valid_r), .xfer_chan_r(xfer_chan_r), .xfer_src_r(xfer_src_r),
		.xfer_dst_r(xfer_dst_r), .blk_active(blk_active), .blk_done_r(blk_done_r),
		.blk_err_r(blk_err_r), .irq_done_r(irq_done_r), .irq_reload_r(irq_reload_r));

	chain_mem_model mem (.clk(clk), .rst_n(rst_n), .chain_req_r(chain_req_r),
		.chain_addr_r(chain_addr_r), .img(img), .chain_ack(chain_ack),
		.chain_data(chain_data), .last_addr(last_addr));

	// ==========================================
	// event monitors
	always @(posedge clk) begin
		if (irq_done_r === 1'b1) n_done++;
		if (irq_reload_r === 1'b1) n_reload++;
		if (xfer_valid_r === 1'b1) begin
			n_xf++;
			last_x = {xfer_chan_r, xfer_src_r, xfer_dst_r};
		end
	end

	// ==========================================
	// shared helpers
	task automatic chk(input logic [127:0] got, exp, input string what);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	function automatic logic [31:0] ctl(input logic [2:0] ty, input logic ie, ch,
		input logic [2:0] tg, input logic [18:0] p);
		return {ty, 4'h0, ie, 1'b0, ch, tg, p};
	endfunction

	task automatic wr(input logic [4:0] s, input logic [127:0] d, input logic q);
		@(negedge clk);
		blk_wr = 1'b1;
		blk_quad = q;
		blk_sel = s;
		blk_wdata = d;
		@(negedge clk);
		blk_wr = 1'b0;
	endtask

	task automatic rd(input logic [4:0] s, input logic [127:0] exp);
		@(negedge clk);
		blk_rd = 1'b1;
		blk_quad = 1'b1;
		blk_sel = s;
		@(negedge clk);
		blk_rd = 1'b0;
		chk(blk_rvalid_r, 1'b1, "read valid");
		chk(blk_rdata_r, exp, "read image");
	endtask

	// requester drops its level in the cycle the transfer shows
	task automatic xfer(input logic [9:0] r, input logic [3:0] ch, input logic [31:0] s, d);
		int i;
		@(negedge clk);
		req = r;
		i = 0;
		while (xfer_valid_r !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		req = '0;
		chk(xfer_valid_r, 1'b1, "xfer pulse");
		chk({xfer_chan_r, xfer_src_r, xfer_dst_r}, {ch, s, d}, "xfer fields");
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		logic [127:0] b;
		b = {ctl(3'h0, 1'b1, 1'b1, 3'h5, 19'h1_2345), 32'h1234_5678, 32'h0003_0001, 32'h0000_0100};
		wr(5'd8, b, 1'b1);
		rd(5'd8, b);
		wr(5'd8, ~b, 1'b0);
		wr(5'd20, ~b, 1'b1);
		rd(5'd8, b);
		@(negedge clk);
		blk_rd = 1'b1;
		blk_quad = 1'b0;
		@(negedge clk);
		blk_rd = 1'b0;
		chk(blk_rvalid_r, 1'b0, "narrow read answered");
		chk(blk_active[8], 1'b0, "inactive after type zero");
		$display("test regs done");
	endtask

	task automatic t_rx();
		int n0;
		n0 = n_done;
		wr(5'd12, {ctl(3'h2, 1'b1, 1'b0, 3'h0, '0), 32'h0001_0005, 32'h0002_0001, 32'h0000_1000}, 1'b1);
		chk(blk_active[12], 1'b1, "rx active");
		xfer(10'h010, 4'd8, 32'h0, 32'h0000_1000);
		chk({blk_done_r[12], 32'(n_done - n0)}, 33'h0, "no early finish");
		xfer(10'h010, 4'd8, 32'h0, 32'h0000_1001);
		repeat (2) @(negedge clk);
		chk({blk_active[12], blk_done_r[12], 32'(n_done - n0)}, {2'b01, 32'd1}, "rx end");
		$display("test rx done");
	endtask

	task automatic t_reload();
		int n0;
		logic [127:0] b;
		n0 = n_reload;
		b = {ctl(3'h2, 1'b0, 1'b0, 3'h0, '0), 32'h0, 32'h0005_0001, 32'h0000_1100};
		wr(5'd12, b, 1'b1);
		wr(5'd12, b, 1'b1);
		repeat (2) @(negedge clk);
		chk({blk_err_r[12], 32'(n_reload - n0)}, {1'b1, 32'd1}, "reload flagged");
		wr(5'd12, {ctl(3'h0, 1'b0, 1'b0, 3'h0, '0), 96'h0}, 1'b1);
		@(negedge clk);
		chk({blk_active[12], blk_err_r[12], blk_done_r[12]}, 3'b000, "reinit");
		n0 = n_xf;
		req = 10'h010;
		repeat (5) @(negedge clk);
		req = '0;
		chk(32'(n_xf - n0), 32'd0, "inactive ignored");
		$display("test reload done");
	endtask

	task automatic t_long();
		int n0;
		n0 = n_done;
		wr(5'd13, {ctl(3'h3, 1'b0, 1'b0, 3'h0, '0), 32'h0, {10'd2, 22'h01_0003},
			32'h0000_2000}, 1'b1);
		xfer(10'h020, 4'd9, 32'h0, 32'h0000_2000);
		xfer(10'h020, 4'd9, 32'h0, 32'h0001_2003);
		repeat (2) @(negedge clk);
		chk({blk_done_r[13], 32'(n_done - n0)}, {1'b1, 32'd0}, "long split end");
		$display("test long done");
	endtask

	// two rows of two, row jump of 0x10 from a row's last element
	task automatic t_twod();
		int n0;
		n0 = n_done;
		wr(5'd14, {ctl(3'h2, 1'b1, 1'b0, 3'h0, '0) | 32'h0800_0000, 32'h0002_0010,
			32'h0002_0001, 32'h0000_6000}, 1'b1);
		xfer(10'h040, 4'd10, 32'h0, 32'h0000_6000);
		xfer(10'h040, 4'd10, 32'h0, 32'h0000_6001);
		xfer(10'h040, 4'd10, 32'h0, 32'h0000_6011);
		chk(blk_done_r[14], 1'b0, "finish before last row");
		xfer(10'h040, 4'd10, 32'h0, 32'h0000_6012);
		repeat (2) @(negedge clk);
		chk({blk_active[14], blk_done_r[14], 32'(n_done - n0)}, {2'b01, 32'd1}, "2d end");
		$display("test twod done");
	endtask

	task automatic t_chain();
		int i;
		int n0;
		n0 = n_done;
		img = {ctl(3'h2, 1'b1, 1'b0, 3'h0, '0), 32'h0, 32'h0001_0001, 32'h0000_3000};
		wr(5'd8, {ctl(3'h2, 1'b0, 1'b1, 3'h4, 19'h0_0010), 32'h0, 32'h0001_0001, 32'h0000_0500}, 1'b1);
		xfer(10'h001, 4'd4, 32'h0000_0500, 32'h0);
		i = 0;
		while (blk_active[8] !== 1'b1 && i < 30) begin
			@(negedge clk);
			i++;
		end
		chk(last_addr, 21'h00_0040, "chain address");
		rd(5'd8, img);
		xfer(10'h001, 4'd4, 32'h0000_3000, 32'h0);
		repeat (2) @(negedge clk);
		chk(32'(n_done - n0), 32'd1, "chained finish irq");
		$display("test chain done");
	endtask

	task automatic t_ext();
		int n0;
		n0 = n_xf;
		wr(5'd4, {ctl(3'h2, 1'b0, 1'b0, 3'h0, '0), 32'h0, 32'h0001_0001, 32'h0000_4000}, 1'b1);
		wr(5'd0, {ctl(3'h4, 1'b0, 1'b0, 3'h0, '0), 32'h0, 32'h0001_0001, 32'h0000_0800}, 1'b1);
		repeat (5) @(negedge clk);
		chk({32'(n_xf - n0), last_x}, {32'd1, 4'd0, 32'h0000_0800, 32'h0000_4000}, "ext");
		chk({blk_done_r[0], blk_done_r[4]}, 2'b11, "ext done");
		wr(5'd16, {ctl(3'h2, 1'b0, 1'b0, 3'h0, '0), 32'h0, 32'h0001_0001, 32'h0000_5000}, 1'b1);
		xfer(10'h100, 4'd12, 32'h0, 32'h0000_5000);
		$display("test ext done");
	endtask

	// ==========================================
	// run control
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_regs();
		t_rx();
		t_reload();
		t_long();
		t_twod();
		t_chain();
		t_ext();
		print_verdict();
	end

	// whole run is about a hundred cycles
	initial begin
		#20000;
		error_cnt++;
		$display("BAD t=%0t watchdog expired", $time);
		print_verdict();
	end
endmodule

// ### dma_tcb_setup.sv
`timescale 1ns/1ps
module dma_tcb_setup
	import dma_blk_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// control block access
	input  wire logic         blk_wr,
	input  wire logic         blk_rd,
	input  wire logic         blk_quad,
	input  wire logic [4:0]   blk_sel,
	input  wire logic [127:0] blk_wdata,
	output logic      [127:0] blk_rdata_r,
	output logic              blk_rvalid_r,
	// chain loading
	output logic              chain_req_r,
	output logic      [20:0]  chain_addr_r,
	input  wire logic         chain_ack,
	input  wire logic [127:0] chain_data,
	// data movers
	input  wire logic [3:0]   link_tx_ready,
	input  wire logic [3:0]   link_rx_valid,
	input  wire logic [1:0]   auto_wr,
	output logic              xfer_valid_r,
	output logic      [3:0]   xfer_chan_r,
	output logic      [31:0]  xfer_src_r,
	output logic      [31:0]  xfer_dst_r,
	// status and interrupts
	output logic      [17:0]  blk_active,
	output logic      [17:0]  blk_done_r,
	output logic      [17:0]  blk_err_r,
	output logic              irq_done_r,
	output logic              irq_reload_r
);
	// ==========================================
	// block slots
	// ==========================================
	logic [127:0]          img    [NUM_BLK];
	logic [127:0]          ld_dat [NUM_BLK];
	logic [31:0]           baddr  [NUM_BLK];
	logic [NUM_BLK-1:0]    act;
	logic [NUM_BLK-1:0]    last;
	logic [NUM_BLK-1:0]    step;
	logic [NUM_BLK-1:0]    host_hit;
	logic [NUM_BLK-1:0]    chain_hit;
	logic [NUM_BLK-1:0]    ld;
	logic [NUM_BLK-1:0]    ld_off;
	logic [NUM_BLK-1:0]    illegal;
	logic [NUM_BLK-1:0]    fin_int;
	logic [NUM_BLK-1:0]    fin_chain_enable;
	logic [NUM_CHAN-1:0]   chan_req;
	logic [NUM_CHAN-1:0]   chan_flush;
	logic [31:0]           chan_src [NUM_CHAN];
	logic [31:0]           chan_dst [NUM_CHAN];
	chain_fsm_e            cf_r;
	logic [4:0]            chain_tgt_r;
	logic [NUM_CHAN-1:0]   gnt;

	// narrow accesses fall through: no hit, no answer
	wire sel_ok  = blk_sel < 5'(NUM_BLK);
	wire host_ld = blk_wr & blk_quad & sel_ok;
	wire rd_hit  = blk_rd & blk_quad & sel_ok;
	wire chain_ld = (cf_r == CF_WAIT) & chain_ack;

	assign blk_active = act;

	generate
		for (genvar b = 0; b < NUM_BLK; b++) begin : g_blk
			assign host_hit[b]  = host_ld & (blk_sel == 5'(b));
			// a host write to the same block wins over a chain load
			assign chain_hit[b] = chain_ld & (chain_tgt_r == 5'(b)) & ~host_hit[b];
			assign ld[b]        = host_hit[b] | chain_hit[b];
			assign ld_dat[b]    = host_hit[b] ? blk_wdata : chain_data;
			assign ld_off[b]    = ld[b] & (ld_dat[b][CW_LSB + TYPE_LSB +: 3] == TYPE_OFF);
			assign illegal[b]   = ld[b] & act[b] & ~ld_off[b];
			assign fin_int[b]   = last[b] & img[b][CW_LSB + INT_BIT];
			assign fin_chain_enable[b]  = last[b] & img[b][CW_LSB + CHAIN_ENABLE_BIT];

			dma_blk_slot u_slot (
				.clk     (clk),
				.rst_n   (rst_n),
				.load    (ld[b]),
				.ld_data (ld_dat[b]),
				.step    (step[b]),
				.words_r (img[b]),
				.addr_r  (baddr[b]),
				.act_r   (act[b]),
				.last    (last[b])
			);
		end
	endgenerate

	// ==========================================
	// channel map
	// ==========================================
	generate
		for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
			// source and destination step together, one element per grant
			assign chan_req[i]       = act[BLK_SRC + i] & act[BLK_DST + i];
			assign chan_src[i]       = baddr[BLK_SRC + i];
			assign chan_dst[i]       = baddr[BLK_DST + i];
			assign step[BLK_SRC + i] = gnt[i];
			assign step[BLK_DST + i] = gnt[i];
			assign chan_flush[i]     = ld_off[BLK_SRC + i] | ld_off[BLK_DST + i];
		end
		for (genvar i = 0; i < NUM_LINK; i++) begin : g_link
			assign chan_req[CH_LTX + i]   = act[BLK_LTX + i] & link_tx_ready[i];
			assign chan_src[CH_LTX + i]   = baddr[BLK_LTX + i];
			assign chan_dst[CH_LTX + i]   = WORD_RST;
			assign step[BLK_LTX + i]      = gnt[CH_LTX + i];
			assign chan_flush[CH_LTX + i] = ld_off[BLK_LTX + i];
			assign chan_req[CH_LRX + i]   = act[BLK_LRX + i] & link_rx_valid[i];
			assign chan_src[CH_LRX + i]   = WORD_RST;
			assign chan_dst[CH_LRX + i]   = baddr[BLK_LRX + i];
			assign step[BLK_LRX + i]      = gnt[CH_LRX + i];
			assign chan_flush[CH_LRX + i] = ld_off[BLK_LRX + i];
		end
		for (genvar i = 0; i < NUM_WT; i++) begin : g_wt
			assign chan_req[CH_WT + i]   = act[BLK_WT + i] & auto_wr[i];
			assign chan_src[CH_WT + i]   = WORD_RST;
			assign chan_dst[CH_WT + i]   = baddr[BLK_WT + i];
			assign step[BLK_WT + i]      = gnt[CH_WT + i];
			assign chan_flush[CH_WT + i] = ld_off[BLK_WT + i];
		end
	endgenerate

	// ==========================================
	// arbiter
	// ==========================================
	// each requester gets one grant per round, so no channel starves;
	// the channel granted last cycle sits out one cycle so that a
	// level request has time to drop after its transfer shows
	logic [NUM_CHAN-1:0] round_r;
	logic [NUM_CHAN-1:0] last_r;

	wire [NUM_CHAN-1:0] fresh     = chan_req & ~round_r & ~last_r;
	wire [NUM_CHAN-1:0] elig      = (|fresh) ? fresh : chan_req & ~last_r;
	wire [4:0]          gnt_idx   = first_set({4'h0, elig});
	wire [NUM_CHAN-1:0] round_nxt = ((|fresh) ? (round_r | gnt) : gnt) & ~chan_flush;

	assign gnt = elig & (~elig + 14'h0001);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			round_r <= 14'h0000;
			last_r  <= 14'h0000;
		end else begin
			round_r <= round_nxt;
			last_r  <= gnt & ~chan_flush;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_valid_r <= 1'b0;
			xfer_chan_r  <= 4'h0;
			xfer_src_r   <= WORD_RST;
			xfer_dst_r   <= WORD_RST;
		end else begin
			xfer_valid_r <= |gnt;
			xfer_chan_r  <= gnt_idx[3:0];
			xfer_src_r   <= chan_src[gnt_idx[3:0]];
			xfer_dst_r   <= chan_dst[gnt_idx[3:0]];
		end
	end

	// ==========================================
	// chain fetch
	// ==========================================
	logic [NUM_BLK-1:0] pend_r;

	wire [4:0]  pick    = first_set(pend_r);
	wire        issue   = (cf_r == CF_IDLE) & (|pend_r);
	wire [31:0] pick_cw = img[pick][CW_LSB +: 32];
	wire [2:0]  pick_tg = pick_cw[CHTG_LSB +: 3];
	wire        pick_lk = (pick >= 5'(BLK_LTX)) & (pick < 5'(BLK_WT));
	// link blocks may chain into any link block; others reload themselves
	wire [4:0]  tgt_nxt = !pick_lk ? pick :
	                      pick_tg[2] ? 5'(BLK_LTX) + {3'h0, pick_tg[1:0]} :
	                      5'(BLK_LRX) + {3'h0, pick_tg[1:0]};
	wire [NUM_BLK-1:0] pend_clr = issue ? (18'h0_0001 << pick) : 18'h0_0000;
	// new completion wins over the clear of the same block
	wire [NUM_BLK-1:0] pend_nxt = (pend_r & ~pend_clr & ~ld_off) | fin_chain_enable;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_r <= 18'h0_0000;
			cf_r   <= CF_IDLE;
		end else begin
			pend_r <= pend_nxt;
			unique case (cf_r)
				CF_IDLE: if (issue) cf_r <= CF_WAIT;
				CF_WAIT: if (chain_ack) cf_r <= CF_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chain_req_r  <= 1'b0;
			chain_addr_r <= 21'h0_0000;
			chain_tgt_r  <= 5'h00;
		end else if (issue) begin
			chain_req_r  <= 1'b1;
			// pointer holds address bits above the quad-word alignment
			chain_addr_r <= {pick_cw[CHAIN_POINTER_LSB +: CHAIN_POINTER_W], 2'b00};
			chain_tgt_r  <= tgt_nxt;
		end else if (chain_ld) begin
			chain_req_r  <= 1'b0;
		end
	end

	// ==========================================
	// status, interrupts, read back
	// ==========================================
	// any load clears a block's status; a same-cycle event still sets it
	wire [NUM_BLK-1:0] done_nxt = (blk_done_r & ~ld) | last;
	wire [NUM_BLK-1:0] err_nxt  = (blk_err_r & ~ld) | illegal;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blk_done_r   <= 18'h0_0000;
			blk_err_r    <= 18'h0_0000;
			irq_done_r   <= 1'b0;
			irq_reload_r <= 1'b0;
		end else begin
			blk_done_r   <= done_nxt;
			blk_err_r    <= err_nxt;
			irq_done_r   <= |fin_int;
			irq_reload_r <= |illegal;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			blk_rdata_r  <= {4{WORD_RST}};
			blk_rvalid_r <= 1'b0;
		end else begin
			blk_rvalid_r <= rd_hit;
			if (rd_hit) blk_rdata_r <= img[blk_sel];
		end
	end

	// ==========================================
	// checks
	// ==========================================
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	wire [2:0] wr_ty = blk_wdata[CW_LSB + TYPE_LSB +: 3];

	sequence s_two_grants;
		xfer_valid_r ##1 xfer_valid_r;
	endsequence

	sequence s_chain_issue;
		cf_r == CF_IDLE && |pend_r;
	endsequence

	a_narrow_ignored: assert property (
		blk_wr && !blk_quad && !chain_ld |=> !irq_reload_r && !$changed(blk_err_r))
		else $error("narrow write changed channel state");

	a_reload_irq: assert property (
		host_ld && act[blk_sel] && wr_ty != TYPE_OFF |=> irq_reload_r && blk_err_r != 18'h0_0000)
		else $error("active reload raised no interrupt");

	a_reinit_clear: assert property (
		host_ld && wr_ty == TYPE_OFF |=> !blk_active[$past(blk_sel)] && !blk_err_r[$past(blk_sel)])
		else $error("inactive load did not reset channel");

	a_done_irq: assert property (
		|fin_int |=> irq_done_r)
		else $error("completion interrupt missing");

	a_no_irq: assert property (
		irq_done_r |-> $past(|fin_int))
		else $error("interrupt without enabled completion");

	a_grant_spacing: assert property (
		s_two_grants |-> xfer_chan_r != $past(xfer_chan_r))
		else $error("same channel served on two cycles running");

	a_rx_move: assert property (
		link_rx_valid[0] && act[BLK_LRX] |-> ##[1:30]
		((xfer_valid_r && xfer_chan_r == 4'(CH_LRX)) || !act[BLK_LRX] || !link_rx_valid[0]))
		else $error("received word not moved in time");

	a_chain_req: assert property (
		s_chain_issue |=> chain_req_r && chain_addr_r[1:0] == 2'b00 && cf_r == CF_WAIT)
		else $error("chain fetch not issued");

	a_chain_load: assert property (
		chain_ld && !host_hit[chain_tgt_r] |=> img[$past(chain_tgt_r)] == $past(chain_data))
		else $error("chained block not loaded");
endmodule
